// [src/dual_counter_output_demod.sv]
// Control, output and edge demodulation logic of a byte counter and a word counter.
//
// Our own choice: strobed register access.
module dual_counter_output_demod (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic port3_pin1_i,
	input wire logic port2_pin0_i,
	output logic port3_pin4_o,
	output logic port3_pin5_o,
	output logic port3_pin6_o,
	output logic irq_o
);
	import dual_counter_pkg::*;

	logic [7:0] byte_counter_control;
	logic [7:0] common_control;
	logic [7:0] word_counter_control;
	logic [7:0] mode_control;
	logic [7:0] byte_counter_low_hold;
	logic [7:0] byte_counter_high_hold;
	logic [7:0] word_counter_low_hold;
	logic [7:0] word_counter_high_hold;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_enable;
	logic [7:0] byte_count;
	logic [15:0] word_count;
	logic byte_counter_output;
	logic word_counter_output;
	logic byte_run_q;
	logic word_run_q;
	turn_t turn;
	logic edge_in_q;
	logic edge_filt;
	logic [7:0] glitch_cnt;
	logic rise_flag;
	logic fall_flag;

	wire demod = mode_control[BIT_MODE_DEMOD];
	wire [1:0] logic_sel = common_control[5:4];
	wire [1:0] submode = common_control[3:2];
	wire init_byte = common_control[BIT_INIT_BYTE];
	wire init_word = common_control[BIT_INIT_WORD];
	wire byte_en = byte_counter_control[BIT_ENABLE];
	wire word_en = word_counter_control[BIT_ENABLE];
	wire alternating = !demod && submode == SUB_ALTERNATE;
	wire byte_start = byte_en && !byte_run_q;
	wire word_start = word_en && !word_run_q;
	wire byte_tc = byte_en && !byte_start && byte_count == 8'h00;
	wire word_tc = word_en && !word_start && word_count == 16'h0000;
	wire wr_common = wr_i && addr_i == OFF_COMMON_CTRL;
	wire edge_src = mode_control[BIT_EDGE_SOURCE] ? port2_pin0_i : port3_pin1_i;
	wire [7:0] glitch_len = 8'(GLITCH_UNIT_CYCLES) * {6'h00, submode};
	wire rise_seen = demod && edge_in_q && !edge_filt && glitch_cnt >= glitch_len;
	wire fall_seen = demod && !edge_in_q && edge_filt && glitch_cnt >= glitch_len;
	wire rise_hit = rise_seen && (logic_sel == 2'h0 || logic_sel == 2'h2);
	wire fall_hit = fall_seen && (logic_sel == 2'h1 || logic_sel == 2'h2);
	wire clr_rise = wr_common && wdata_i[BIT_INIT_BYTE] && demod;
	wire clr_fall = wr_common && wdata_i[BIT_INIT_WORD] && demod;
	wire [IRQ_BITS-1:0] irq_events = {fall_hit, rise_hit, word_tc, byte_tc};

	function automatic logic gate(input logic [1:0] sel, input logic a, input logic b);
		unique case (sel)
			GATE_AND: gate = a & b;
			GATE_OR: gate = a | b;
			GATE_NOR: gate = ~(a | b);
			GATE_NAND: gate = ~(a & b);
		endcase
	endfunction : gate

	wire combined = gate(logic_sel, byte_counter_output, word_counter_output);

	logic [7:0] next_rdata;
	always_comb begin
		unique case (addr_i)
			OFF_BYTE_CTRL: next_rdata = byte_counter_control;
			OFF_COMMON_CTRL: next_rdata = demod ?
				{common_control[7:2], rise_flag, fall_flag} : common_control;
			OFF_WORD_CTRL: next_rdata = word_counter_control;
			OFF_MODE_CTRL: next_rdata = mode_control;
			OFF_BYTE_LOW: next_rdata = byte_counter_low_hold;
			OFF_BYTE_HIGH: next_rdata = byte_counter_high_hold;
			OFF_WORD_LOW: next_rdata = word_counter_low_hold;
			OFF_WORD_HIGH: next_rdata = word_counter_high_hold;
			OFF_IRQ_STATUS: next_rdata = {4'h0, irq_status};
			OFF_IRQ_ENABLE: next_rdata = {4'h0, irq_enable};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? next_rdata : 8'h00;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			common_control <= RESET_CTRL;
			mode_control <= RESET_CTRL;
			byte_counter_low_hold <= RESET_HOLD;
			byte_counter_high_hold <= RESET_HOLD;
			word_counter_low_hold <= RESET_HOLD;
			word_counter_high_hold <= RESET_HOLD;
			irq_enable <= '0;
		end else if (wr_i) begin
			if (addr_i == OFF_COMMON_CTRL && !demod) common_control <= wdata_i;
			if (addr_i == OFF_COMMON_CTRL && demod) common_control[7:2] <= wdata_i[7:2];
			if (addr_i == OFF_MODE_CTRL) mode_control <= wdata_i;
			if (addr_i == OFF_BYTE_LOW) byte_counter_low_hold <= wdata_i;
			if (addr_i == OFF_BYTE_HIGH) byte_counter_high_hold <= wdata_i;
			if (addr_i == OFF_WORD_LOW) word_counter_low_hold <= wdata_i;
			if (addr_i == OFF_WORD_HIGH) word_counter_high_hold <= wdata_i;
			if (addr_i == OFF_IRQ_ENABLE) irq_enable <= wdata_i[IRQ_BITS-1:0];
		end
	end

	// Control registers: software writes, hardware swaps enables and sets timeouts.
	logic [7:0] next_byte_ctrl;
	logic [7:0] next_word_ctrl;
	always_comb begin
		next_byte_ctrl = byte_counter_control;
		next_word_ctrl = word_counter_control;
		if (wr_i && addr_i == OFF_BYTE_CTRL) next_byte_ctrl = wdata_i;
		if (wr_i && addr_i == OFF_WORD_CTRL) next_word_ctrl = wdata_i;
		if (alternating && byte_tc) begin
			next_byte_ctrl[BIT_ENABLE] = 1'b0;
			next_word_ctrl[BIT_ENABLE] = 1'b1;
		end
		if (alternating && word_tc) begin
			next_word_ctrl[BIT_ENABLE] = 1'b0;
			next_byte_ctrl[BIT_ENABLE] = 1'b1;
		end
		if (byte_tc) next_byte_ctrl[BIT_TIMEOUT] = 1'b1;
		if (word_tc) next_word_ctrl[BIT_TIMEOUT] = 1'b1;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_counter_control <= RESET_CTRL;
			word_counter_control <= RESET_CTRL;
			turn <= TURN_BYTE;
		end else begin
			byte_counter_control <= next_byte_ctrl;
			word_counter_control <= next_word_ctrl;
			if (!alternating) turn <= TURN_BYTE;
			else if (byte_tc) turn <= TURN_WORD;
			else if (word_tc) turn <= TURN_BYTE;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_count <= 8'h00;
			word_count <= 16'h0000;
			byte_run_q <= 1'b0;
			word_run_q <= 1'b0;
		end else begin
			byte_run_q <= byte_en;
			word_run_q <= word_en;
			if (byte_start || byte_tc) byte_count <= byte_counter_low_hold;
			else if (byte_en) byte_count <= byte_count - 8'h01;
			if (word_start || word_tc) word_count <= {word_counter_high_hold, word_counter_low_hold};
			else if (word_en) word_count <= word_count - 16'h0001;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_counter_output <= 1'b1;
			word_counter_output <= 1'b1;
		end else begin
			if (!byte_en) byte_counter_output <= ~init_byte;
			else if (byte_start) byte_counter_output <= init_byte;
			else if (byte_tc) byte_counter_output <= ~byte_counter_output;
			if (!demod && wr_common && wdata_i[3:2] == SUB_FORCE_LOW) begin
				word_counter_output <= 1'b0;
			end else if (!demod && wr_common && wdata_i[3:2] == SUB_FORCE_HIGH) begin
				word_counter_output <= 1'b1;
			end else if (!demod && submode[1]) begin
				word_counter_output <= word_counter_output;
			end else if (!word_en) begin
				word_counter_output <= ~init_word;
			end else if (word_start) begin
				word_counter_output <= init_word;
			end else if (word_tc) begin
				word_counter_output <= ~word_counter_output;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			edge_in_q <= 1'b0;
			edge_filt <= 1'b0;
			glitch_cnt <= 8'h00;
		end else begin
			edge_in_q <= edge_src;
			if (edge_in_q == edge_filt) glitch_cnt <= 8'h00;
			else if (glitch_cnt >= glitch_len) edge_filt <= edge_in_q;
			else glitch_cnt <= glitch_cnt + 8'h01;
			if (edge_in_q != edge_filt && glitch_cnt >= glitch_len) glitch_cnt <= 8'h00;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rise_flag <= 1'b0;
			fall_flag <= 1'b0;
			irq_status <= '0;
			irq_o <= 1'b0;
		end else begin
			if (rise_hit) rise_flag <= 1'b1;
			else if (clr_rise) rise_flag <= 1'b0;
			if (fall_hit) fall_flag <= 1'b1;
			else if (clr_fall) fall_flag <= 1'b0;
			if (wr_i && addr_i == OFF_IRQ_CLEAR) begin
				irq_status <= (irq_status & ~wdata_i[IRQ_BITS-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
			irq_o <= |(irq_status & irq_enable);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			port3_pin4_o <= 1'b0;
			port3_pin5_o <= 1'b0;
			port3_pin6_o <= 1'b0;
		end else begin
			port3_pin4_o <= byte_counter_control[BIT_ROUTE] & byte_counter_output;
			port3_pin5_o <= word_counter_control[BIT_ROUTE] & word_counter_output;
			port3_pin6_o <= common_control[BIT_COMBINE_ROUTE] & combined;
		end
	end

	chk_pin4_route: assert property (@(posedge mclk_i) disable iff (rst_i)
		port3_pin4_o == $past(byte_counter_control[BIT_ROUTE] & byte_counter_output))
		else $error("Pin 4 does not follow the routed byte output.");
	chk_pin5_route: assert property (@(posedge mclk_i) disable iff (rst_i)
		!$past(word_counter_control[BIT_ROUTE]) |-> !port3_pin5_o)
		else $error("Pin 5 driven while word route is off.");
	chk_pin5_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
		$past(word_counter_control[BIT_ROUTE]) |->
		port3_pin5_o == $past(word_counter_output))
		else $error("Pin 5 does not follow the routed word output.");
	chk_pin6_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		$past(common_control[6]) |-> port3_pin6_o ==
		gate($past(logic_sel), $past(byte_counter_output), $past(word_counter_output)))
		else $error("Pin 6 does not show the selected gate.");
	chk_pin6_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		!$past(common_control[BIT_COMBINE_ROUTE]) |-> !port3_pin6_o)
		else $error("Pin 6 driven while the combined route is off.");
	chk_byte_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		!byte_en ##1 !byte_en |-> byte_counter_output == ~$past(init_byte))
		else $error("Idle byte output is not the inverse level.");
	chk_byte_start: assert property (@(posedge mclk_i) disable iff (rst_i)
		byte_start |=> byte_counter_output == $past(init_byte))
		else $error("Byte output missed its initial level.");
	chk_byte_timeout: assert property (@(posedge mclk_i) disable iff (rst_i)
		byte_tc |=> byte_counter_control[BIT_TIMEOUT])
		else $error("Byte timeout flag not set at terminal count.");
	chk_word_force: assert property (@(posedge mclk_i) disable iff (rst_i)
		!demod && wr_common && wdata_i[3:2] == SUB_FORCE_LOW |=> !word_counter_output)
		else $error("Word output not forced low.");
	chk_word_high: assert property (@(posedge mclk_i) disable iff (rst_i)
		!demod && wr_common && wdata_i[3:2] == SUB_FORCE_HIGH |=> word_counter_output)
		else $error("Word output not forced high.");
	chk_word_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		!demod && submode[1] && !(wr_common && wdata_i[3])
		|=> $stable(word_counter_output))
		else $error("Forced word output did not hold.");
	chk_word_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		!word_en && (demod || !submode[1]) && !(!demod && wr_common && wdata_i[3])
		|=> word_counter_output == ~$past(init_word))
		else $error("Idle word output is not the inverse level.");
	chk_word_start: assert property (@(posedge mclk_i) disable iff (rst_i)
		word_start && (demod || !submode[1]) && !(!demod && wr_common && wdata_i[3])
		|=> word_counter_output == $past(init_word))
		else $error("Word output missed its initial level.");
	chk_rise_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		rise_hit |=> rise_flag)
		else $error("Rise flag not set after a rising edge.");
	chk_rise_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		clr_rise && !rise_hit |=> !rise_flag)
		else $error("Rise flag not cleared by software.");
	chk_rise_only: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(rise_flag) |-> $past(rise_hit))
		else $error("Rise flag set without a rising edge.");
	chk_edge_select: assert property (@(posedge mclk_i) disable iff (rst_i)
		rise_seen && logic_sel[0] == 1'b0 |=> rise_flag)
		else $error("Selected rising edge not recognised.");
	chk_fall_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		fall_hit |=> fall_flag)
		else $error("Fall flag not set after a falling edge.");
	chk_fall_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		clr_fall && !fall_hit |=> !fall_flag)
		else $error("Fall flag not cleared by software.");
	chk_fall_only: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(fall_flag) |-> $past(fall_hit))
		else $error("Fall flag set without a falling edge.");
	chk_fall_select: assert property (@(posedge mclk_i) disable iff (rst_i)
		fall_seen && (logic_sel == 2'h1 || logic_sel == 2'h2) |=> fall_flag)
		else $error("Selected falling edge not recognised.");
	chk_edge_none: assert property (@(posedge mclk_i) disable iff (rst_i)
		demod && logic_sel == 2'h3 && !rise_flag |=> !rise_flag)
		else $error("Rise flag set while no edge is selected.");
	chk_glitch_width: assert property (@(posedge mclk_i) disable iff (rst_i)
		$changed(edge_filt) |-> $past(glitch_cnt >= glitch_len))
		else $error("Filtered level changed before the glitch width.");
	chk_edge_source: assert property (@(posedge mclk_i) disable iff (rst_i)
		edge_in_q == $past(edge_src))
		else $error("Edge input not taken from the selected pin.");
	chk_demod_init: assert property (@(posedge mclk_i) disable iff (rst_i)
		demod && wr_common |=> common_control[1:0] == $past(common_control[1:0]))
		else $error("Demodulation write changed the initial-level bits.");
	chk_rise_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
		!demod |=> $stable(rise_flag) && $stable(fall_flag))
		else $error("Edge flags changed in transmit mode.");
	chk_alt_swap: assert property (@(posedge mclk_i) disable iff (rst_i)
		alternating && byte_tc && !word_tc |=> word_en && !byte_en)
		else $error("Alternating hand-over to the word counter failed.");
	chk_alt_back: assert property (@(posedge mclk_i) disable iff (rst_i)
		alternating && word_tc && !byte_tc |=> byte_en && !word_en)
		else $error("Alternating hand-over to the byte counter failed.");
	chk_alt_turn: assert property (@(posedge mclk_i) disable iff (rst_i)
		alternating && byte_tc && !word_tc |=> turn == TURN_WORD)
		else $error("Turn did not pass to the word counter.");
	chk_normal_turn: assert property (@(posedge mclk_i) disable iff (rst_i)
		!alternating |=> turn == TURN_BYTE)
		else $error("Turn not reset in normal operation.");
	chk_normal_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		!alternating && !wr_i |=> $stable(byte_en) && $stable(word_en))
		else $error("Enable changed by hardware in normal operation.");
	chk_timeout_set: assert property (@(posedge mclk_i) disable iff (rst_i)
		word_tc |=> word_counter_control[BIT_TIMEOUT])
		else $error("Word timeout flag not set at terminal count.");
endmodule : dual_counter_output_demod

// [src/dual_counter_pkg.sv]
// Package with register offsets, field positions and reset values of the dual counter block.
// Summary of operation
// - Transmit mode: combined output is AND, OR, NOR or NAND of both counter outputs.
// - Demodulation mode: the same field selects rising, falling or both edges.
// - Transmit submode selects alternating or normal; normal ends alternating operation.
// - Submode 10 forces word counter output low at once; 11 forces it high.
// - Demodulation mode: submode field sets the glitch width filtered before detection.
// - Byte counter output takes the initial-level bit when counting starts.
// - Disabled byte counter holds output at the inverse of its initial level.
// - Rising edge sets rise flag; software writing one clears it.
// - Word counter output takes its initial level at start, except in transmit submodes 10 and 11.
// - Disabled word counter holds output at the inverse of its initial level, except in transmit submodes 10 and 11.
// - Falling edge sets fall flag; software writing one clears it.
// - Alternating operation: hardware enables the two counters in turn, one at a time.
// - Alternating operation: each timeout flag sets at every terminal count.
// - Byte control bit 0 routes byte counter output to port 3 pin 4.
// - Word control bit 0 routes word counter output to port 3 pin 5.
// - Common control bit 6 drives port 3 pin 6 with the gate combination.
// - Edge input is taken from port 3 pin 1 or port 2 pin 0.
package dual_counter_pkg;
	localparam logic [3:0] OFF_BYTE_CTRL = 4'h0;
	localparam logic [3:0] OFF_COMMON_CTRL = 4'h1;
	localparam logic [3:0] OFF_WORD_CTRL = 4'h2;
	localparam logic [3:0] OFF_MODE_CTRL = 4'h3;
	localparam logic [3:0] OFF_BYTE_LOW = 4'h4;
	localparam logic [3:0] OFF_BYTE_HIGH = 4'h5;
	localparam logic [3:0] OFF_WORD_LOW = 4'h6;
	localparam logic [3:0] OFF_WORD_HIGH = 4'h7;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFF_IRQ_ENABLE = 4'h9;
	localparam logic [3:0] OFF_IRQ_CLEAR = 4'ha;
	localparam int BIT_ROUTE = 0;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_INIT_BYTE = 1;
	localparam int BIT_INIT_WORD = 0;
	localparam int BIT_COMBINE_ROUTE = 6;
	localparam int BIT_MODE_DEMOD = 0;
	localparam int BIT_EDGE_SOURCE = 1;
	localparam logic [7:0] RESET_CTRL = 8'h00;
	localparam logic [7:0] RESET_HOLD = 8'h00;
	localparam logic [1:0] GATE_AND = 2'h0;
	localparam logic [1:0] GATE_OR = 2'h1;
	localparam logic [1:0] GATE_NOR = 2'h2;
	localparam logic [1:0] GATE_NAND = 2'h3;
	localparam logic [1:0] SUB_NORMAL = 2'h0;
	localparam logic [1:0] SUB_ALTERNATE = 2'h1;
	localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
	localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;
	localparam int IRQ_BITS = 4;
	localparam int GLITCH_UNIT_CYCLES = 4;
	typedef enum logic {TURN_BYTE, TURN_WORD} turn_t;
endpackage : dual_counter_pkg

// [verif/edge_pin_model.sv]
// Model of the external pins that feed the edge input of the block.
module edge_pin_model (
	input wire logic mclk_i,
	output logic port3_pin1_o,
	output logic port2_pin0_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		port3_pin1_o = 1'b0;
		port2_pin0_o = 1'b0;
	end
	// Drives one source pin to a level and holds it; short holds act as glitches.
	task automatic drive(input logic src, input logic val, input int cyc);
		@(posedge mclk_i);
		if (src) begin
			port2_pin0_o <= val;
		end else begin
			port3_pin1_o <= val;
		end
		repeat (cyc - 1) @(posedge mclk_i);
	endtask : drive
	// A high pulse of a given width, then a low stretch long enough to settle.
	task automatic pulse(input logic src, input int w);
		drive(src, 1'b1, w);
		drive(src, 1'b0, 8);
	endtask : pulse
endmodule : edge_pin_model

// [verif/dual_counter_output_demod_bench.sv]
// Self-checking bench for the dual counter output and demodulation block.
module dual_counter_output_demod_bench import dual_counter_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic port3_pin1_i, port2_pin0_i, port3_pin4_o, port3_pin5_o, port3_pin6_o, irq_o;
	logic [7:0] pin_bits;
	int fails = 0;
	int check_count = 0;
	assign pin_bits = {5'h00, port3_pin6_o, port3_pin5_o, port3_pin4_o};
	dual_counter_output_demod i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.port3_pin1_i(port3_pin1_i), .port2_pin0_i(port2_pin0_i),
		.port3_pin4_o(port3_pin4_o), .port3_pin5_o(port3_pin5_o),
		.port3_pin6_o(port3_pin6_o), .irq_o(irq_o));
	edge_pin_model i_pins (.mclk_i(mclk_i), .port3_pin1_o(port3_pin1_i),
		.port2_pin0_o(port2_pin0_i));
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		d = rdata_o;
	endtask : rd
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic check_reg(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check_byte(d, exp);
	endtask : check_reg
	task automatic settle();
		repeat (3) @(negedge mclk_i);
	endtask : settle
	task automatic test_reset();
		check_byte(pin_bits, 8'h00);
		check_reg(OFF_BYTE_CTRL, RESET_CTRL);
		check_reg(OFF_COMMON_CTRL, RESET_CTRL);
		check_reg(OFF_WORD_HIGH, RESET_HOLD);
		check_reg(4'hf, 8'h00);
	endtask : test_reset
	task automatic test_gates();
		logic a, b, g;
		wr(OFF_BYTE_CTRL, 8'h01);
		wr(OFF_WORD_CTRL, 8'h01);
		for (int i = 0; i < 16; i++) begin
			a = ~i[1];
			b = ~i[0];
			g = (i[3:2] == GATE_AND) ? (a & b) : (i[3:2] == GATE_OR) ? (a | b) :
				(i[3:2] == GATE_NOR) ? ~(a | b) : ~(a & b);
			wr(OFF_COMMON_CTRL, {2'b01, i[3:2], 2'b00, i[1:0]});
			settle();
			check_byte(pin_bits, {5'h00, g, b, a});
		end
	endtask : test_gates
	task automatic test_start();
		wr(OFF_BYTE_LOW, 8'h40);
		wr(OFF_WORD_LOW, 8'h40);
		wr(OFF_COMMON_CTRL, 8'h03);
		wr(OFF_BYTE_CTRL, 8'h81);
		settle();
		check_byte(pin_bits & 8'h03, 8'h01);
		wr(OFF_WORD_CTRL, 8'h81);
		settle();
		check_byte(pin_bits & 8'h02, 8'h02);
		wr(OFF_COMMON_CTRL, 8'h0b);
		settle();
		check_byte(pin_bits & 8'h02, 8'h00);
		wr(OFF_COMMON_CTRL, 8'h0f);
		settle();
		check_byte(pin_bits & 8'h02, 8'h02);
		wr(OFF_BYTE_CTRL, 8'h00);
		wr(OFF_WORD_CTRL, 8'h00);
	endtask : test_start
	task automatic test_alternate();
		logic [7:0] b, w, sb, sw;
		sb = 8'h00;
		sw = 8'h00;
		wr(OFF_COMMON_CTRL, 8'h04);
		wr(OFF_BYTE_LOW, 8'h04);
		wr(OFF_WORD_LOW, 8'h04);
		wr(OFF_WORD_HIGH, 8'h00);
		wr(OFF_BYTE_CTRL, 8'h80);
		for (int i = 0; i < 20; i++) begin
			rd(OFF_BYTE_CTRL, b);
			rd(OFF_WORD_CTRL, w);
			sb = sb | b;
			sw = sw | w;
		end
		check_byte(sb & 8'ha0, 8'ha0);
		check_byte(sw & 8'ha0, 8'ha0);
		wr(OFF_COMMON_CTRL, 8'h00);
		rd(OFF_BYTE_CTRL, b);
		rd(OFF_WORD_CTRL, w);
		check_byte((b ^ w) & 8'h80, 8'h80);
		for (int i = 0; i < 8; i++) begin
			check_reg(OFF_BYTE_CTRL, b);
			check_reg(OFF_WORD_CTRL, w);
		end
		check_reg(OFF_IRQ_STATUS, 8'h03);
		wr(OFF_BYTE_CTRL, 8'h00);
		wr(OFF_WORD_CTRL, 8'h00);
	endtask : test_alternate
	task automatic test_demod();
		wr(OFF_MODE_CTRL, 8'h01);
		wr(OFF_IRQ_CLEAR, 8'h0f);
		wr(OFF_IRQ_ENABLE, 8'h04);
		wr(OFF_COMMON_CTRL, 8'h23);
		i_pins.pulse(1'b0, 8);
		check_reg(OFF_COMMON_CTRL, 8'h23);
		check_byte({7'h00, irq_o}, 8'h01);
		wr(OFF_COMMON_CTRL, 8'h23);
		check_reg(OFF_COMMON_CTRL, 8'h20);
		wr(OFF_IRQ_CLEAR, 8'h04);
		check_reg(OFF_IRQ_STATUS, 8'h08);
		check_byte({7'h00, irq_o}, 8'h00);
		wr(OFF_COMMON_CTRL, 8'h03);
		i_pins.pulse(1'b0, 8);
		check_reg(OFF_COMMON_CTRL, 8'h02);
		wr(OFF_COMMON_CTRL, 8'h13);
		i_pins.pulse(1'b0, 8);
		check_reg(OFF_COMMON_CTRL, 8'h11);
		wr(OFF_MODE_CTRL, 8'h03);
		wr(OFF_COMMON_CTRL, 8'h23);
		i_pins.pulse(1'b0, 8);
		check_reg(OFF_COMMON_CTRL, 8'h20);
		i_pins.pulse(1'b1, 8);
		check_reg(OFF_COMMON_CTRL, 8'h23);
		wr(OFF_COMMON_CTRL, 8'h27);
		i_pins.pulse(1'b1, 2);
		check_reg(OFF_COMMON_CTRL, 8'h24);
		i_pins.pulse(1'b1, 10);
		check_reg(OFF_COMMON_CTRL, 8'h27);
		wr(OFF_COMMON_CTRL, 8'h33);
		i_pins.pulse(1'b1, 10);
		check_reg(OFF_COMMON_CTRL, 8'h30);
	endtask : test_demod
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		test_reset();
		test_gates();
		test_start();
		test_alternate();
		test_demod();
		end_sim();
	end
	initial begin
		#500000;
		fails++;
		end_sim();
	end
endmodule : dual_counter_output_demod_bench
